// File: cpurf_defs.svh
// Purpose: constants of the cpu register file block
// Assumes: 32-bit data path, one clock
// Notes:   definitions only
`ifndef CPURF_DEFS_SVH
`define CPURF_DEFS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define CPURF_NUM_GPR      16
`define CPURF_AW           4
`define CPURF_DW           32
`define CPURF_DSP_W        64

// ----------------------------------------
// state word fields
// ----------------------------------------
`define CPURF_ST_CARRY     0
`define CPURF_ST_ZERO      1
`define CPURF_ST_SIGN      2
`define CPURF_ST_OVF       3
`define CPURF_ST_FLAGS_W   4
`define CPURF_ST_IRQ_EN    16
`define CPURF_ST_USER      17

// ----------------------------------------
// reset values
// ----------------------------------------
`define CPURF_PC_RST       32'h00000000
`define CPURF_ST_RST       32'h00000000
`define CPURF_PTR_RST      32'h00000000
`define CPURF_DSP_RST      64'h0000000000000000

// ----------------------------------------
// dsp half-word fields and vector layout
// ----------------------------------------
`define CPURF_DSP_HI_LSB   32
`define CPURF_DSP_MID_LSB  16
`define CPURF_VEC_SHIFT    2

`endif

// File: cpurf_pkg.sv
// Purpose: types shared by the cpu register file block
// Assumes: constants live in cpurf_defs.svh
// Notes:   none
package cpurf_pkg;

  // ----------------------------------------
  // control register selector
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEL_INT_STACK  = 3'h0,
    SEL_USER_STACK = 3'h1,
    SEL_VEC_BASE   = 3'h2,
    SEL_PROG_CTR   = 3'h3,
    SEL_STATE      = 3'h4,
    SEL_SAVED_PC   = 3'h5,
    SEL_SAVED_ST   = 3'h6,
    SEL_FAST_TGT   = 3'h7
  } cpurf_ctrl_sel_type;

  // ----------------------------------------
  // dsp operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    DSP_NONE    = 3'h0,
    DSP_SWIDE   = 3'h1,
    DSP_UWIDE   = 3'h2,
    DSP_PROD    = 3'h3,
    DSP_RMAC    = 3'h4,
    DSP_LOAD_HI = 3'h5,
    DSP_LOAD_LO = 3'h6
  } cpurf_dsp_op_type;

  // ----------------------------------------
  // posted write buffer state
  // ----------------------------------------
  typedef enum logic {
    POST_IDLE = 1'b0,
    POST_BUSY = 1'b1
  } cpurf_post_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } cpurf_io_wr_type;

  typedef struct packed {
    logic               en;
    cpurf_ctrl_sel_type sel;
    logic [31:0]        data;
  } cpurf_ctrl_wr_type;

endpackage

// File: cpurf_post_buf.sv
// Purpose: one-entry posted write holder toward the peripheral bus
// Assumes: requester and peripheral side share sys_clk
// Notes:   requester is never stalled by a write in flight
`timescale 1ns/10ps

module cpurf_post_buf
  import cpurf_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  input  wire logic            wrValid,
  input  wire cpurf_io_wr_type wrReq,
  input  wire logic            ioReady,
  output logic                 pending,
  output cpurf_io_wr_type      ioWr
);

  cpurf_post_state_type state_q;
  cpurf_post_state_type state_d;
  cpurf_io_wr_type      hold_q;
  cpurf_io_wr_type      hold_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    hold_d  = hold_q;
    case (state_q)
      POST_IDLE:
      begin
        if (wrValid)
        begin
          // write is taken here and the caller moves on
          state_d = POST_BUSY;
          hold_d  = wrReq;
        end
      end
      POST_BUSY:
      begin
        if (ioReady)
        begin
          state_d = POST_IDLE;
        end
      end
      default:
      begin
        state_d = POST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= POST_IDLE;
      hold_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      hold_q  <= hold_d;
    end
  end

  assign pending = (state_q == POST_BUSY);
  assign ioWr    = hold_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  post_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pending && !ioReady |=> pending && $stable(ioWr))
    else $error("posted write dropped before completion");

  post_take_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pending && wrValid |=> pending && ioWr == $past(wrReq))
    else $error("posted write not captured");

  post_done_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    pending ##1 pending ##1 !pending);

endmodule

// File: cpurf_top.sv
// Purpose: cpu register set with stack select, fast interrupt backup,
//          dsp sum register and posted peripheral writes
// Assumes: all inputs come from core logic on sys_clk
// Notes:   read ports answer one cycle after the address
//
// Behaviour
// - sixteen general registers, data or address use
// - register zero doubles as stack pointer
// - user bit selects interrupt or user stack
// - vector base gives vector table start
// - program counter holds executing instruction address
// - state word holds flags and cpu state
// - fast interrupt saves program counter
// - fast interrupt saves state word, same layout
// - fast interrupt branches to fast target
// - dsp sum register is 64 bits wide
// - product ops overwrite dsp sum register, except rmac which adds to it
// - load high and low halves
// - fetch high and middle halves
// - peripheral writes are posted
`timescale 1ns/10ps
`include "cpurf_defs.svh"

module cpurf_top
  import cpurf_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  gprWe,
  input  wire logic [`CPURF_AW-1:0]  gprWrAddr,
  input  wire logic [`CPURF_DW-1:0]  gprWrData,
  input  wire logic [`CPURF_AW-1:0]  rdAddrA,
  input  wire logic [`CPURF_AW-1:0]  rdAddrB,
  input  wire cpurf_ctrl_wr_type     ctrlWr,
  input  wire cpurf_ctrl_sel_type    ctrlRdSel,
  input  wire logic                  pcWe,
  input  wire logic [`CPURF_DW-1:0]  pcWrData,
  input  wire logic                  flagWe,
  input  wire logic [3:0]            flagsIn,
  input  wire logic                  fastIrqTake,
  input  wire logic                  fastIrqReturn,
  input  wire logic [7:0]            vecIndex,
  input  wire cpurf_dsp_op_type      dspOp,
  input  wire logic [`CPURF_DW-1:0]  dspSrcA,
  input  wire logic [`CPURF_DW-1:0]  dspSrcB,
  input  wire logic                  dspFetchMid,
  input  wire logic                  ioWrValid,
  input  wire cpurf_io_wr_type       ioWrReq,
  input  wire logic                  ioReady,
  output logic [`CPURF_DW-1:0]       rdDataA_q,
  output logic [`CPURF_DW-1:0]       rdDataB_q,
  output logic [`CPURF_DW-1:0]       ctrlRdData_q,
  output logic [`CPURF_DW-1:0]       pc_q,
  output logic [`CPURF_DW-1:0]       stateWord_q,
  output logic [`CPURF_DW-1:0]       vecAddr_q,
  output logic [`CPURF_DW-1:0]       dspFetch_q,
  output logic                       ioPending,
  output cpurf_io_wr_type            ioWr
);

  logic [`CPURF_DW-1:0]    gpr_q [1:`CPURF_NUM_GPR-1];
  logic [`CPURF_DW-1:0]    gpr_d [1:`CPURF_NUM_GPR-1];
  logic [`CPURF_DW-1:0]    intStack_q;
  logic [`CPURF_DW-1:0]    intStack_d;
  logic [`CPURF_DW-1:0]    userStack_q;
  logic [`CPURF_DW-1:0]    userStack_d;
  logic [`CPURF_DW-1:0]    vecBase_q;
  logic [`CPURF_DW-1:0]    vecBase_d;
  logic [`CPURF_DW-1:0]    fastTarget_q;
  logic [`CPURF_DW-1:0]    fastTarget_d;
  logic [`CPURF_DW-1:0]    savedPc_q;
  logic [`CPURF_DW-1:0]    savedPc_d;
  logic [`CPURF_DW-1:0]    savedState_q;
  logic [`CPURF_DW-1:0]    savedState_d;
  logic [`CPURF_DW-1:0]    pc_d;
  logic [`CPURF_DW-1:0]    stateWord_d;
  logic [`CPURF_DSP_W-1:0] dsp_q;
  logic [`CPURF_DSP_W-1:0] dsp_d;
  logic [`CPURF_DSP_W-1:0] prodSigned;
  logic [`CPURF_DSP_W-1:0] prodUnsigned;
  logic                    userMode;

  assign userMode = stateWord_q[`CPURF_ST_USER];

  // ----------------------------------------
  // read decode, with write-through bypass
  // ----------------------------------------
  function automatic logic [`CPURF_DW-1:0] readGpr(
    input logic [`CPURF_AW-1:0] addr
  );
    logic [`CPURF_DW-1:0] val;
    val = '0;
    if (gprWe && gprWrAddr == addr)
    begin
      val = gprWrData;
    end
    else if (addr == '0)
    begin
      // register zero is whichever stack pointer is active
      val = userMode ? userStack_q : intStack_q;
    end
    else
    begin
      val = gpr_q[addr];
    end
    return val;
  endfunction

  // ----------------------------------------
  // general registers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi < `CPURF_NUM_GPR; gi++)
    begin : g_gpr
      always_comb
      begin
        gpr_d[gi] = gpr_q[gi];
        if (gprWe && gprWrAddr == `CPURF_AW'(gi))
        begin
          gpr_d[gi] = gprWrData;
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          gpr_q[gi] <= '0;
        end
        else
        begin
          gpr_q[gi] <= gpr_d[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // priority: fast entry, fast return, control write, core update
  always_comb
  begin
    intStack_d   = intStack_q;
    userStack_d  = userStack_q;
    vecBase_d    = vecBase_q;
    fastTarget_d = fastTarget_q;
    savedPc_d    = savedPc_q;
    savedState_d = savedState_q;
    pc_d         = pc_q;
    stateWord_d  = stateWord_q;
    if (gprWe && gprWrAddr == '0)
    begin
      if (userMode)
      begin
        userStack_d = gprWrData;
      end
      else
      begin
        intStack_d = gprWrData;
      end
    end
    if (pcWe)
    begin
      pc_d = pcWrData;
    end
    if (flagWe)
    begin
      stateWord_d[`CPURF_ST_FLAGS_W-1:0] = flagsIn;
    end
    if (ctrlWr.en)
    begin
      case (ctrlWr.sel)
        SEL_INT_STACK:  intStack_d   = ctrlWr.data;
        SEL_USER_STACK: userStack_d  = ctrlWr.data;
        SEL_VEC_BASE:   vecBase_d    = ctrlWr.data;
        SEL_PROG_CTR:   pc_d         = ctrlWr.data;
        SEL_STATE:      stateWord_d  = ctrlWr.data;
        SEL_SAVED_PC:   savedPc_d    = ctrlWr.data;
        SEL_SAVED_ST:   savedState_d = ctrlWr.data;
        SEL_FAST_TGT:   fastTarget_d = ctrlWr.data;
        default:        pc_d         = pc_q;
      endcase
    end
    if (fastIrqTake)
    begin
      savedPc_d    = pc_q;
      savedState_d = stateWord_q;
      pc_d         = fastTarget_q;
      // handler runs on the interrupt stack with interrupts masked
      stateWord_d  = stateWord_q;
      stateWord_d[`CPURF_ST_USER]   = 1'b0;
      stateWord_d[`CPURF_ST_IRQ_EN] = 1'b0;
    end
    else if (fastIrqReturn)
    begin
      pc_d        = savedPc_q;
      stateWord_d = savedState_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      intStack_q   <= `CPURF_PTR_RST;
      userStack_q  <= `CPURF_PTR_RST;
      vecBase_q    <= `CPURF_PTR_RST;
      fastTarget_q <= `CPURF_PTR_RST;
      savedPc_q    <= `CPURF_PC_RST;
      savedState_q <= `CPURF_ST_RST;
      pc_q         <= `CPURF_PC_RST;
      stateWord_q  <= `CPURF_ST_RST;
    end
    else
    begin
      intStack_q   <= intStack_d;
      userStack_q  <= userStack_d;
      vecBase_q    <= vecBase_d;
      fastTarget_q <= fastTarget_d;
      savedPc_q    <= savedPc_d;
      savedState_q <= savedState_d;
      pc_q         <= pc_d;
      stateWord_q  <= stateWord_d;
    end
  end

  // ----------------------------------------
  // dsp sum register
  // ----------------------------------------
  assign prodSigned   = {{32{dspSrcA[31]}}, dspSrcA} * {{32{dspSrcB[31]}}, dspSrcB};
  assign prodUnsigned = {32'h00000000, dspSrcA} * {32'h00000000, dspSrcB};

  always_comb
  begin
    dsp_d = dsp_q;
    case (dspOp)
      DSP_SWIDE:   dsp_d = prodSigned;
      DSP_UWIDE:   dsp_d = prodUnsigned;
      DSP_PROD:    dsp_d = {32'h00000000, prodSigned[31:0]};
      DSP_RMAC:    dsp_d = dsp_q + prodSigned;
      DSP_LOAD_HI: dsp_d = {dspSrcA, dsp_q[31:0]};
      DSP_LOAD_LO: dsp_d = {dsp_q[63:32], dspSrcA};
      default:     dsp_d = dsp_q;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dsp_q <= `CPURF_DSP_RST;
    end
    else
    begin
      dsp_q <= dsp_d;
    end
  end

  // ----------------------------------------
  // registered read ports
  // ----------------------------------------
  logic [`CPURF_DW-1:0] rdDataA_d;
  logic [`CPURF_DW-1:0] rdDataB_d;
  logic [`CPURF_DW-1:0] ctrlRd_d;
  logic [`CPURF_DW-1:0] vecAddr_d;
  logic [`CPURF_DW-1:0] dspFetch_d;

  always_comb
  begin
    rdDataA_d = readGpr(rdAddrA);
    rdDataB_d = readGpr(rdAddrB);
    vecAddr_d = vecBase_q + {22'h0, vecIndex, 2'h0};
    dspFetch_d = dspFetchMid
      ? dsp_q[`CPURF_DSP_MID_LSB +: `CPURF_DW]
      : dsp_q[`CPURF_DSP_HI_LSB +: `CPURF_DW];
    case (ctrlRdSel)
      SEL_INT_STACK:  ctrlRd_d = intStack_q;
      SEL_USER_STACK: ctrlRd_d = userStack_q;
      SEL_VEC_BASE:   ctrlRd_d = vecBase_q;
      SEL_PROG_CTR:   ctrlRd_d = pc_q;
      SEL_STATE:      ctrlRd_d = stateWord_q;
      SEL_SAVED_PC:   ctrlRd_d = savedPc_q;
      SEL_SAVED_ST:   ctrlRd_d = savedState_q;
      SEL_FAST_TGT:   ctrlRd_d = fastTarget_q;
      default:        ctrlRd_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdDataA_q    <= '0;
      rdDataB_q    <= '0;
      ctrlRdData_q <= '0;
      vecAddr_q    <= '0;
      dspFetch_q   <= '0;
    end
    else
    begin
      rdDataA_q    <= rdDataA_d;
      rdDataB_q    <= rdDataB_d;
      ctrlRdData_q <= ctrlRd_d;
      vecAddr_q    <= vecAddr_d;
      dspFetch_q   <= dspFetch_d;
    end
  end

  // ----------------------------------------
  // posted peripheral writes
  // ----------------------------------------
  // only one write in flight; a second offer while pending is ignored
  cpurf_post_buf cpurf_post_buf_i (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wrValid (ioWrValid),
    .wrReq   (ioWrReq),
    .ioReady (ioReady),
    .pending (ioPending),
    .ioWr    (ioWr)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  gpr_write_a: assert property (
    gprWe && gprWrAddr != '0 ##1 rdAddrA == $past(gprWrAddr) && !gprWe
    |=> rdDataA_q == $past(gprWrData, 2))
    else $error("general register lost its write");

  stack_sel_a: assert property (
    rdAddrB == '0 && !gprWe |=> rdDataB_q ==
    ($past(userMode) ? $past(userStack_q) : $past(intStack_q)))
    else $error("register zero shows wrong stack pointer");

  fast_save_a: assert property (
    fastIrqTake |=> savedPc_q == $past(pc_q) && savedState_q == $past(stateWord_q))
    else $error("fast entry did not save counter and state");

  fast_branch_a: assert property (
    fastIrqTake |=> pc_q == $past(fastTarget_q) && !stateWord_q[`CPURF_ST_USER])
    else $error("fast entry did not branch to target");

  fast_ret_a: assert property (
    fastIrqReturn && !fastIrqTake
    |=> pc_q == $past(savedPc_q) && stateWord_q == $past(savedState_q))
    else $error("fast return did not restore");

  wide_signed_a: assert property (
    dspOp == DSP_SWIDE |=> $signed(dsp_q) ==
    $signed($past(dspSrcA)) * $signed($past(dspSrcB)))
    else $error("signed wide product wrong");

  load_hi_a: assert property (
    dspOp == DSP_LOAD_HI
    |=> dsp_q[63:32] == $past(dspSrcA) && dsp_q[31:0] == $past(dsp_q[31:0]))
    else $error("high half load wrong");

  fetch_mid_a: assert property (
    dspFetchMid |=> dspFetch_q == $past(dsp_q[47:16]))
    else $error("middle half fetch wrong");

  vec_addr_a: assert property (
    !ctrlWr.en ##1 1'b1 |-> vecAddr_q == $past(vecBase_q) + 32'($past(vecIndex)) * 4)
    else $error("vector address wrong");

  flags_a: assert property (
    flagWe && !ctrlWr.en && !fastIrqTake && !fastIrqReturn
    |=> stateWord_q[3:0] == $past(flagsIn))
    else $error("flags not recorded");

  fast_round_c: cover property (fastIrqTake ##[1:20] fastIrqReturn);
  rmac_run_c: cover property (dspOp == DSP_RMAC [*3]);
  user_push_c: cover property (userMode && gprWe && gprWrAddr == '0);

endmodule

// File: cpu_register_file_fast_irq_bench.sv
// Purpose: self-checking bench for the cpu register file top
// Assumes: after the blocking time-zero initial values, every input but sys_clk is driven by non-blocking assignment at the rising edge of sys_clk
// Notes:   assertions live in the design files; the chk task here compares outputs with expected values
`timescale 1ns/10ps
`include "cpurf_defs.svh"

module cpu_register_file_fast_irq_bench
  import cpurf_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                 sys_clk;
  logic                 reset_n;
  logic                 gprWe;
  logic [3:0]           gprWrAddr;
  logic [31:0]          gprWrData;
  logic [3:0]           rdAddrA;
  logic [3:0]           rdAddrB;
  cpurf_ctrl_wr_type    ctrlWr;
  cpurf_ctrl_sel_type   ctrlRdSel;
  logic                 pcWe;
  logic [31:0]          pcWrData;
  logic                 flagWe;
  logic [3:0]           flagsIn;
  logic                 fastIrqTake;
  logic                 fastIrqReturn;
  logic [7:0]           vecIndex;
  cpurf_dsp_op_type     dspOp;
  logic [31:0]          dspSrcA;
  logic [31:0]          dspSrcB;
  logic                 dspFetchMid;
  logic                 ioWrValid;
  cpurf_io_wr_type      ioWrReq;
  logic                 ioReady;
  logic [31:0]          rdDataA_q;
  logic [31:0]          rdDataB_q;
  logic [31:0]          ctrlRdData_q;
  logic [31:0]          pc_q;
  logic [31:0]          stateWord_q;
  logic [31:0]          vecAddr_q;
  logic [31:0]          dspFetch_q;
  logic                 ioPending;
  cpurf_io_wr_type      ioWr;
  int                   errTotal;
  int                   totalChecks;

  cpurf_top cpurf_top_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .gprWe(gprWe), .gprWrAddr(gprWrAddr),
    .gprWrData(gprWrData), .rdAddrA(rdAddrA), .rdAddrB(rdAddrB), .ctrlWr(ctrlWr),
    .ctrlRdSel(ctrlRdSel), .pcWe(pcWe), .pcWrData(pcWrData), .flagWe(flagWe),
    .flagsIn(flagsIn), .fastIrqTake(fastIrqTake), .fastIrqReturn(fastIrqReturn),
    .vecIndex(vecIndex), .dspOp(dspOp), .dspSrcA(dspSrcA), .dspSrcB(dspSrcB),
    .dspFetchMid(dspFetchMid), .ioWrValid(ioWrValid), .ioWrReq(ioWrReq),
    .ioReady(ioReady), .rdDataA_q(rdDataA_q), .rdDataB_q(rdDataB_q),
    .ctrlRdData_q(ctrlRdData_q), .pc_q(pc_q), .stateWord_q(stateWord_q),
    .vecAddr_q(vecAddr_q), .dspFetch_q(dspFetch_q), .ioPending(ioPending), .ioWr(ioWr)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (errTotal == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr_gpr(input logic [3:0] a, input logic [31:0] d);
    tick();
    gprWe <= 1'b1;
    gprWrAddr <= a;
    gprWrData <= d;
    tick();
    gprWe <= 1'b0;
  endtask

  task automatic wr_ctrl(input cpurf_ctrl_sel_type s, input logic [31:0] d);
    tick();
    ctrlWr <= '{en: 1'b1, sel: s, data: d};
    tick();
    ctrlWr <= '{en: 1'b0, sel: SEL_INT_STACK, data: 32'h00000000};
  endtask

  task automatic chk_ctrl(input cpurf_ctrl_sel_type s, input logic [31:0] exp);
    tick();
    ctrlRdSel <= s;
    tick();
    #1 chk("control read", {32'h00000000, ctrlRdData_q}, {32'h00000000, exp});
  endtask

  task automatic chk_gpr(input logic [3:0] a, input logic [31:0] expA,
                         input logic [3:0] b, input logic [31:0] expB);
    tick();
    rdAddrA <= a;
    rdAddrB <= b;
    tick();
    #1 chk("read port a", {32'h00000000, rdDataA_q}, {32'h00000000, expA});
    chk("read port b", {32'h00000000, rdDataB_q}, {32'h00000000, expB});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic gpr_bank();
    // back-to-back writes to every register, then cross reads on both ports
    for (int i = 0; i < 16; i++)
    begin
      tick();
      gprWe <= 1'b1;
      gprWrAddr <= 4'(i);
      gprWrData <= 32'hA5A50000 | 32'(i);
    end
    tick();
    gprWe <= 1'b0;
    for (int i = 0; i < 16; i++)
      chk_gpr(4'(i), 32'hA5A50000 | 32'(i), 4'(15 - i), 32'hA5A50000 | 32'(15 - i));
    tick();
    gprWe <= 1'b1;
    gprWrAddr <= 4'h5;
    gprWrData <= 32'h5A5A1234;
    rdAddrA <= 4'h5;
    tick();
    gprWe <= 1'b0;
    #1 chk("bypass read", {32'h00000000, rdDataA_q}, 64'h000000005A5A1234);
  endtask

  task automatic stack_select();
    wr_ctrl(SEL_STATE, 32'h00000000);
    wr_gpr(4'h0, 32'h00001000);
    chk_ctrl(SEL_INT_STACK, 32'h00001000);
    wr_ctrl(SEL_STATE, 32'h00020000);
    wr_gpr(4'h0, 32'h00002000);
    chk_ctrl(SEL_USER_STACK, 32'h00002000);
    chk_ctrl(SEL_INT_STACK, 32'h00001000);
    chk_gpr(4'h0, 32'h00002000, 4'h1, 32'hA5A50001);
    wr_ctrl(SEL_STATE, 32'h00000000);
    chk_gpr(4'h0, 32'h00001000, 4'h0, 32'h00001000);
    wr_ctrl(SEL_USER_STACK, 32'h00003000);
    chk_ctrl(SEL_USER_STACK, 32'h00003000);
  endtask

  task automatic vec_and_pc();
    wr_ctrl(SEL_VEC_BASE, 32'h00004000);
    chk_ctrl(SEL_VEC_BASE, 32'h00004000);
    tick();
    vecIndex <= 8'h05;
    tick(2);
    #1 chk("vector address", {32'h00000000, vecAddr_q}, 64'h0000000000004014);
    tick();
    vecIndex <= 8'hFF;
    tick(2);
    #1 chk("vector address top", {32'h00000000, vecAddr_q}, 64'h00000000000043FC);
    tick();
    pcWe <= 1'b1;
    pcWrData <= 32'h00001234;
    flagWe <= 1'b1;
    flagsIn <= 4'hA;
    tick();
    pcWe <= 1'b0;
    flagWe <= 1'b0;
    #1 chk("program counter", {32'h00000000, pc_q}, 64'h0000000000001234);
    chk("state flags", {60'h0, stateWord_q[3:0]}, 64'h000000000000000A);
  endtask

  task automatic fast_irq();
    // state carries flags plus user and irq-enable bits before entry
    wr_ctrl(SEL_STATE, 32'h0003000A);
    wr_ctrl(SEL_FAST_TGT, 32'h00008000);
    chk_ctrl(SEL_FAST_TGT, 32'h00008000);
    tick();
    fastIrqTake <= 1'b1;
    tick();
    fastIrqTake <= 1'b0;
    #1 chk("fast entry pc", {32'h00000000, pc_q}, 64'h0000000000008000);
    chk("fast entry state", {32'h00000000, stateWord_q}, 64'h000000000000000A);
    chk_ctrl(SEL_SAVED_PC, 32'h00001234);
    chk_ctrl(SEL_SAVED_ST, 32'h0003000A);
    tick();
    fastIrqReturn <= 1'b1;
    tick();
    fastIrqReturn <= 1'b0;
    #1 chk("fast return pc", {32'h00000000, pc_q}, 64'h0000000000001234);
    chk("fast return state", {32'h00000000, stateWord_q}, 64'h000000000003000A);
    chk_ctrl(SEL_STATE, 32'h0003000A);
    chk_ctrl(SEL_PROG_CTR, 32'h00001234);
    wr_ctrl(SEL_STATE, 32'h00000000);
  endtask

  task automatic dsp_case(input cpurf_dsp_op_type op, input logic [31:0] a,
                          input logic [31:0] b, input logic [63:0] exp);
    tick();
    dspOp <= op;
    dspSrcA <= a;
    dspSrcB <= b;
    dspFetchMid <= 1'b0;
    tick();
    dspOp <= DSP_NONE;
    tick(2);
    #1 chk("sum high half", {32'h00000000, dspFetch_q}, {32'h00000000, exp[63:32]});
    tick();
    dspFetchMid <= 1'b1;
    tick(2);
    #1 chk("sum middle half", {32'h00000000, dspFetch_q}, {32'h00000000, exp[47:16]});
  endtask

  task automatic dsp_ops();
    logic [63:0] acc;
    logic [31:0] a;
    logic [31:0] b;
    a = 32'hFFFD0003;
    b = 32'h00070002;
    acc = 64'h89ABCDEF00000000;
    dsp_case(DSP_LOAD_HI, 32'h89ABCDEF, 32'h00000000, acc);
    acc = 64'h89ABCDEF01234567;
    dsp_case(DSP_LOAD_LO, 32'h01234567, 32'h00000000, acc);
    acc = 64'($signed(a)) * 64'($signed(b));
    dsp_case(DSP_SWIDE, a, b, acc);
    acc = {32'h00000000, a} * {32'h00000000, b};
    dsp_case(DSP_UWIDE, a, b, acc);
    acc = 64'($signed(a)) * 64'($signed(b));
    acc = {32'h00000000, acc[31:0]};
    dsp_case(DSP_PROD, a, b, acc);
    acc = acc + 64'($signed(a)) * 64'($signed(b));
    dsp_case(DSP_RMAC, a, b, acc);
  endtask

  task automatic posted_write();
    tick();
    ioWrValid <= 1'b1;
    ioWrReq <= '{addr: 32'h00087000, data: 32'h000000C3};
    tick();
    ioWrValid <= 1'b0;
    #1 chk("write pending", {63'h0, ioPending}, 64'h1);
    chk("held write", ioWr, 64'h00087000000000C3);
    // an offer while busy must be ignored, and the core must not stall
    tick();
    ioWrValid <= 1'b1;
    ioWrReq <= '{addr: 32'h00087004, data: 32'h0000003C};
    gprWe <= 1'b1;
    gprWrAddr <= 4'h9;
    gprWrData <= 32'h0BADF00D;
    tick();
    ioWrValid <= 1'b0;
    gprWe <= 1'b0;
    #1 chk("held write kept", ioWr, 64'h00087000000000C3);
    chk_gpr(4'h9, 32'h0BADF00D, 4'h9, 32'h0BADF00D);
    chk("still pending", {63'h0, ioPending}, 64'h1);
    tick();
    ioReady <= 1'b1;
    tick();
    ioReady <= 1'b0;
    #1 chk("write drained", {63'h0, ioPending}, 64'h0);
    tick();
    ioWrValid <= 1'b1;
    ioWrReq <= '{addr: 32'h00087004, data: 32'h0000003C};
    tick();
    ioWrValid <= 1'b0;
    #1 chk("second write", ioWr, 64'h000870040000003C);
    tick();
    ioReady <= 1'b1;
    tick();
    ioReady <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    errTotal = 0;
    totalChecks = 0;
    reset_n = 1'b0;
    {gprWe, gprWrAddr, gprWrData, rdAddrA, rdAddrB} = '0;
    ctrlWr = '{en: 1'b0, sel: SEL_INT_STACK, data: 32'h00000000};
    ctrlRdSel = SEL_INT_STACK;
    {pcWe, pcWrData, flagWe, flagsIn, fastIrqTake, fastIrqReturn, vecIndex} = '0;
    dspOp = DSP_NONE;
    {dspSrcA, dspSrcB, dspFetchMid, ioWrValid, ioReady} = '0;
    ioWrReq = '{addr: 32'h00000000, data: 32'h00000000};
    tick(12);
    reset_n <= 1'b1;
    tick();
    #1 chk("reset pc", {32'h00000000, pc_q}, {32'h00000000, `CPURF_PC_RST});
    chk("reset state", {32'h00000000, stateWord_q}, {32'h00000000, `CPURF_ST_RST});
    chk("reset pending", {63'h0, ioPending}, 64'h0);
    gpr_bank();
    stack_select();
    vec_and_pc();
    fast_irq();
    dsp_ops();
    posted_write();
    tally_and_finish();
  end

  initial
  begin
    // the whole run is far shorter; reaching this bound means a hang
    for (int i = 0; i < 20000; i++)
      @(posedge sys_clk);
    errTotal++;
    tally_and_finish();
  end
endmodule
